/* hdl/seq_regs.svh */
// register offsets, field positions, codes and timing counts of the sequencer
`ifndef SEQ_REGS_SVH
`define SEQ_REGS_SVH
`define REG_CMD 6'h00
`define REG_CTRL 6'h01
`define REG_MSGLEN 6'h02
`define REG_CDBCFG 6'h03
`define REG_RETRY 6'h04
`define REG_TMO 6'h05
`define REG_INT 6'h06
`define REG_STAT 6'h07
`define CTRL_AUTO_ACK 0
`define CTRL_AUTO_RX 1
`define CTRL_INIT 2
`define CMD_PARITY 8
`define CODE_RESET 8'h01
`define CODE_TMO 8'h2c
`define CODE_FREE 8'h31
`define CODE_PHCHG 8'h32
`define CODE_BADPH 8'h54
`define CODE_RXMSG 8'h55
`define CODE_RXSTS 8'h56
`define CODE_DONE 8'h60
`define CODE_DOUBLE 8'h64
`define CODE_ILLEGAL 8'h65
`define CODE_PARITY 8'h66
`define CODE_PAUSE 8'h67
`define CODE_LATEFREE 8'h70
`define CODE_SELTMO 8'h82
`define STEP_0 8'h00
`define STEP_1 8'h01
`define STEP_2 8'h02
`define STEP_3 8'h03
`define STEP_4 8'h04
`define STEP_5 8'h05
`define STEP_AUTO_OR 8'h08
`define MSG_MAX 8'h20
`define SEL_TMO_CYC 16'h0100
`define QUEUE_DEPTH 2'h2
`endif

/* hdl/seq_pkg.sv */
// types shared by the sequencer files
package seq_pkg;
	typedef enum logic [4:0] {
		op_send_data = 5'h00,
		op_recv_data = 5'h01,
		op_send_status = 5'h02,
		op_recv_cmd = 5'h03,
		op_sel_cmd = 5'h04,
		op_sel_1msg_cmd = 5'h05,
		op_sel_nmsg_cmd = 5'h06
	} op_t;
	typedef enum logic [2:0] {
		st_idle = 3'h0,
		st_bus_free = 3'h1,
		st_arb = 3'h2,
		st_sel = 3'h3,
		st_xfer = 3'h4,
		st_after = 3'h5
	} state_t;
	typedef enum logic [2:0] {
		ph_data_out = 3'h0,
		ph_data_in = 3'h1,
		ph_command = 3'h2,
		ph_status = 3'h3,
		ph_msg_out = 3'h6,
		ph_msg_in = 3'h7
	} phase_t;
endpackage

/* hdl/int_queue.sv */
// two-entry queue of pending code/step pairs with registered read data
`timescale 1ns/1ns
`default_nettype none
`include "seq_regs.svh"
module int_queue (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic push,
	input wire logic [15:0] push_data,
	input wire logic pop,
	output logic [15:0] head,
	output logic not_empty
);
	typedef struct packed {
		logic [15:0] e0;
		logic [15:0] e1;
		logic [1:0] cnt;
		logic [15:0] head;
		logic ne;
	} q_t;
	q_t q, next_q;
	// pop shifts, push appends; full queue drops the newest entry
	always_comb begin
		next_q = q;
		if (pop && q.cnt != 2'h0) begin
			next_q.e0 = q.e1;
			next_q.cnt = q.cnt - 2'h1;
		end
		if (push && next_q.cnt != `QUEUE_DEPTH) begin
			if (next_q.cnt == 2'h0)
				next_q.e0 = push_data;
			else
				next_q.e1 = push_data;
			next_q.cnt = next_q.cnt + 2'h1;
		end
		next_q.head = next_q.e0;
		next_q.ne = (next_q.cnt != 2'h0);
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			q <= '0;
		else
			q <= next_q;
	end
	assign head = q.head;
	assign not_empty = q.ne;
endmodule
`default_nettype wire

/* hdl/phase_sequencer.sv */
// phase sequencer: runs commands, reports code/step pairs over AHB-Lite
`timescale 1ns/1ns
`default_nettype none
`include "seq_regs.svh"
module phase_sequencer (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic bus_free,
	input wire logic bus_reset,
	input wire logic arb_won,
	input wire logic arb_lost,
	input wire logic reselected,
	input wire logic sel_busy,
	input wire logic cmd_pause,
	input wire logic req,
	input wire logic [2:0] req_phase,
	input wire logic byte_done,
	input wire logic req_ack_timeout,
	input wire logic single_msg_in,
	input wire logic single_status_in,
	output logic [2:0] drive_phase,
	output logic phase_drive,
	output logic atn,
	output logic ack_held,
	output logic busy
);
	typedef struct packed {
		seq_pkg::state_t st;
		seq_pkg::op_t op;
		logic [7:0] step;
		logic [7:0] left;
		logic [3:0] tries;
		logic [15:0] seltmr;
		logic first_req;
		logic msg_done;
		logic nexus;
		logic double_pend;
		logic resel_pend;
		logic [2:0] ctrl;
		logic [7:0] msglen;
		logic [7:0] cdbcfg;
		logic [3:0] retry;
		logic [7:0] xlen;
		logic wr_pend;
		logic rd_pend;
		logic [5:0] widx;
		logic [31:0] rdata;
		logic [2:0] phase;
		logic pdrive;
		logic atn;
		logic ackh;
		logic busy;
	} s_t;
	s_t s, next_s;
	logic push;
	logic [15:0] push_data;
	logic pop;
	logic [15:0] head;
	logic not_empty;
	logic [5:0] ridx;
	logic [8:0] wcmd;

	int_queue u_queue (
		.hclk(hclk),
		.hresetn(hresetn),
		.push(push),
		.push_data(push_data),
		.pop(pop),
		.head(head),
		.not_empty(not_empty)
	);

	// odd parity over the command byte and its parity bit
	function automatic logic par_bad(input logic [8:0] w);
		par_bad = ~^w;
	endfunction
	// true for ops that begin with a selection
	function automatic logic is_sel(input seq_pkg::op_t o);
		is_sel = (o == seq_pkg::op_sel_cmd) || (o == seq_pkg::op_sel_1msg_cmd)
			|| (o == seq_pkg::op_sel_nmsg_cmd);
	endfunction

	// address phase decode, read index follows the current address
	assign ridx = haddr[7:2];
	assign wcmd = hwdata[8:0];
	assign pop = hsel && hready && htrans[1] && !hwrite
		&& ridx == `REG_INT && not_empty;

	// whole sequencer: bus slave, command decode and phase walk
	always_comb begin
		next_s = s;
		push = 1'b0;
		push_data = '0;
		next_s.wr_pend = hsel && hready && htrans[1] && hwrite;
		next_s.rd_pend = hsel && hready && htrans[1] && !hwrite;
		if (next_s.wr_pend)
			next_s.widx = ridx;
		// read data registered for the data phase
		next_s.rdata = '0;
		if (next_s.rd_pend) begin
			unique case (ridx)
				`REG_CTRL: next_s.rdata = {29'h0, s.ctrl};
				`REG_MSGLEN: next_s.rdata = {24'h0, s.msglen};
				`REG_CDBCFG: next_s.rdata = {24'h0, s.cdbcfg};
				`REG_RETRY: next_s.rdata = {28'h0, s.retry};
				`REG_INT: next_s.rdata = {15'h0, not_empty, head};
				`REG_STAT: next_s.rdata = {16'h0, s.step, 2'h0, s.nexus,
					s.busy, 1'b0, s.st};
				default: next_s.rdata = '0;
			endcase
		end
		// register writes and command intake
		if (s.wr_pend) begin
			unique case (s.widx)
				`REG_CTRL: next_s.ctrl = hwdata[2:0];
				`REG_MSGLEN: next_s.msglen = hwdata[7:0];
				`REG_CDBCFG: next_s.cdbcfg = hwdata[7:0];
				`REG_RETRY: next_s.retry = hwdata[3:0];
				`REG_CMD: begin
					if (par_bad(wcmd)) begin
						push = 1'b1;
						push_data = {`CODE_PARITY, `STEP_0};
					end else if (s.st != seq_pkg::st_idle) begin
						next_s.double_pend = 1'b1;
					end else if (not_empty) begin
						push = 1'b1;
						push_data = {`CODE_DOUBLE, `STEP_0};
					end else if (wcmd[7:5] != 3'h0
						|| wcmd[4:0] > 5'h06
						|| (s.ctrl[`CTRL_INIT] && wcmd[4:0] < 5'h04)
						|| (wcmd[4:0] < 5'h04 && !s.nexus)
						|| (wcmd[4:0] >= 5'h04 && s.nexus)) begin
						push = 1'b1;
						push_data = {`CODE_ILLEGAL, `STEP_0};
					end else begin
						next_s.op = seq_pkg::op_t'(wcmd[4:0]);
						next_s.step = `STEP_0;
						next_s.busy = 1'b1;
						next_s.tries = '0;
						next_s.msg_done = 1'b0;
						next_s.first_req = 1'b1;
						next_s.xlen = s.msglen;
						next_s.st = is_sel(next_s.op) ? seq_pkg::st_bus_free
							: seq_pkg::st_xfer;
					end
				end
				default: ;
			endcase
		end
		// idle: ack left held in manual mode is released at bus free and reported as free
		if (s.st == seq_pkg::st_idle && s.ackh && bus_free) begin
			next_s.ackh = 1'b0;
			push = 1'b1;
			push_data = {`CODE_FREE, `STEP_0};
		end
		unique case (s.st)
			seq_pkg::st_idle: ;
			seq_pkg::st_bus_free: begin
				if (bus_reset) begin
					push = 1'b1;
					push_data = {`CODE_RESET, `STEP_0};
					next_s.st = seq_pkg::st_idle;
				end else if (reselected && s.resel_pend) begin
					push = 1'b1;
					push_data = {`CODE_DOUBLE, `STEP_0};
					next_s.nexus = 1'b1;
					next_s.st = seq_pkg::st_idle;
				end else if (bus_free) begin
					next_s.step = `STEP_1;
					next_s.st = seq_pkg::st_arb;
				end
			end
			seq_pkg::st_arb: begin
				if (bus_reset) begin
					push = 1'b1;
					push_data = {`CODE_RESET, `STEP_1};
					next_s.st = seq_pkg::st_idle;
				end else if (cmd_pause) begin
					push = 1'b1;
					push_data = {`CODE_PAUSE, `STEP_1};
					next_s.st = seq_pkg::st_idle;
				end else if (arb_lost) begin
					next_s.resel_pend = 1'b1;
					next_s.step = `STEP_0;
					next_s.st = seq_pkg::st_bus_free;
				end else if (arb_won) begin
					next_s.step = `STEP_2;
					next_s.seltmr = '0;
					next_s.st = seq_pkg::st_sel;
				end
			end
			seq_pkg::st_sel: begin
				next_s.seltmr = s.seltmr + 16'h1;
				if (bus_reset) begin
					push = 1'b1;
					push_data = {`CODE_RESET, `STEP_2};
					next_s.st = seq_pkg::st_idle;
				end else if (sel_busy) begin
					next_s.nexus = 1'b1;
					next_s.resel_pend = 1'b0;
					next_s.atn = (s.op != seq_pkg::op_sel_cmd);
					next_s.step = `STEP_3;
					next_s.st = seq_pkg::st_xfer;
					if (s.op == seq_pkg::op_sel_1msg_cmd && s.msglen > `MSG_MAX) begin
						push = 1'b1;
						push_data = {`CODE_DOUBLE, `STEP_3};
						next_s.atn = 1'b0;
						next_s.st = seq_pkg::st_idle;
					end
				end else if (s.seltmr == `SEL_TMO_CYC) begin
					next_s.seltmr = '0;
					if (s.tries == s.retry) begin
						push = 1'b1;
						push_data = {`CODE_SELTMO, `STEP_2};
						next_s.st = seq_pkg::st_idle;
					end else begin
						next_s.tries = s.tries + 4'h1;
						next_s.step = `STEP_0;
						next_s.st = seq_pkg::st_bus_free;
					end
				end
			end
			seq_pkg::st_xfer: begin
				if (!is_sel(s.op)) begin
					next_s.step = `STEP_1;
					next_s.pdrive = 1'b1;
					unique case (s.op)
						seq_pkg::op_send_data: next_s.phase = seq_pkg::ph_data_in;
						seq_pkg::op_recv_data: next_s.phase = seq_pkg::ph_data_out;
						seq_pkg::op_send_status: next_s.phase = seq_pkg::ph_status;
						default: next_s.phase = seq_pkg::ph_command;
					endcase
					if (s.pdrive && byte_done) begin
						next_s.left = s.left - 8'h1;
						if (s.left == 8'h1 || s.op == seq_pkg::op_send_status) begin
							push = 1'b1;
							push_data = {`CODE_DONE, `STEP_2};
							next_s.pdrive = 1'b0;
							next_s.st = seq_pkg::st_idle;
						end
					end
					if (!s.pdrive)
						next_s.left = s.xlen;
				end else if (bus_reset) begin
					push = 1'b1;
					push_data = {`CODE_RESET, s.step};
					next_s.st = seq_pkg::st_idle;
				end else if (req_ack_timeout) begin
					push = 1'b1;
					push_data = {`CODE_TMO, s.step};
					next_s.st = seq_pkg::st_idle;
				end else if (bus_free) begin
					push = 1'b1;
					push_data = {s.first_req ? `CODE_LATEFREE : `CODE_FREE,
						s.first_req ? `STEP_2 : s.step};
					next_s.nexus = 1'b0;
					next_s.st = seq_pkg::st_idle;
				end else if (req) begin
					next_s.first_req = 1'b0;
					if (s.first_req && req_phase != ((s.atn && !s.msg_done)
						? seq_pkg::ph_msg_out : seq_pkg::ph_command)) begin
						next_s.st = seq_pkg::st_idle;
						push = 1'b1;
						if (s.ctrl[`CTRL_AUTO_RX] && single_msg_in) begin
							push_data = {`CODE_RXMSG, s.step};
							next_s.atn = 1'b0;
						end else if (s.ctrl[`CTRL_AUTO_RX] && single_status_in) begin
							push_data = {`CODE_RXSTS, s.step};
							next_s.atn = 1'b0;
						end else begin
							push_data = {`CODE_BADPH, s.step};
						end
					end else if (!s.first_req && req_phase != s.phase) begin
						push = 1'b1;
						push_data = {`CODE_PHCHG, s.step};
						next_s.st = seq_pkg::st_idle;
					end else if (req_phase == seq_pkg::ph_command && s.first_req
						&& (s.cdbcfg == 8'h00 || wcmd_grp(s.cdbcfg))) begin
						push = 1'b1;
						push_data = {`CODE_ILLEGAL, s.step};
						next_s.st = seq_pkg::st_idle;
					end else begin
						next_s.phase = req_phase;
					end
				end else if (byte_done) begin
					if (s.atn && !s.msg_done) begin
						next_s.msg_done = 1'b1;
						next_s.atn = 1'b0;
						next_s.first_req = 1'b1;
						next_s.step = `STEP_4;
					end else begin
						next_s.st = seq_pkg::st_after;
						next_s.step = s.step + 8'h1;
						next_s.ackh = !s.ctrl[`CTRL_AUTO_ACK];
						push = 1'b1;
						push_data = {`CODE_DONE, s.ctrl[`CTRL_AUTO_ACK]
							? (s.step + 8'h1) | `STEP_AUTO_OR
							: s.step + 8'h1};
					end
				end
			end
			seq_pkg::st_after: begin
				next_s.st = seq_pkg::st_idle;
			end
			default: next_s.st = seq_pkg::st_idle;
		endcase
		// deferred double reception reported after the result
		if (s.double_pend && next_s.st == seq_pkg::st_idle && !push) begin
			push = 1'b1;
			push_data = {`CODE_DOUBLE, `STEP_0};
			next_s.double_pend = s.wr_pend && s.widx == `REG_CMD
				&& !par_bad(wcmd); // a command landing now: set wins
		end
		if (next_s.st == seq_pkg::st_idle) begin
			next_s.busy = 1'b0;
			if (is_sel(s.op))
				next_s.pdrive = 1'b0;
		end
	end

	// group 3/4 descriptor flagged by the descriptor group field
	function automatic logic wcmd_grp(input logic [7:0] c);
		wcmd_grp = (c[7:5] == 3'h3) || (c[7:5] == 3'h4);
	endfunction

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			s <= '0;
		else
			s <= next_s;
	end

	// outputs straight from the state register, hreadyout and hresp tied off
	assign hrdata = s.rdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign drive_phase = s.phase;
	assign phase_drive = s.pdrive;
	assign atn = s.atn;
	assign ack_held = s.ackh;
	assign busy = s.busy;
endmodule
`default_nettype wire

/* tb/seq_chk.sv */
// port checker for the phase sequencer
`timescale 1ns/1ns
`default_nettype none
module seq_chk (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic bus_free,
	input wire logic bus_reset,
	input wire logic req_ack_timeout,
	input wire logic ack_held,
	input wire logic busy
);
	logic take;
	logic rd;
	logic [2:0] cmd_seen;
	// address phase accepted by the slave
	assign take = hsel && hready && htrans[1];
	assign rd = take && !hwrite;
	// recent command register writes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cmd_seen <= 3'h0;
		end else begin
			cmd_seen <= {cmd_seen[1:0], take && hwrite && haddr[7:0] == 8'h00};
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	property p_ready;
		hreadyout == 1'b1;
	endproperty
	a_ready: assert property (p_ready) else $error("wait state seen");
	property p_okay;
		hresp == 1'b0;
	endproperty
	a_okay: assert property (p_okay) else $error("error response seen");
	property p_unmapped;
		rd && haddr[7:5] != 3'h0 && haddr[31:8] == 24'h0 |=> hrdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read data");
	property p_int_fmt;
		rd && haddr[7:0] == 8'h18 |=> hrdata[31:17] == 15'h0;
	endproperty
	a_int_fmt: assert property (p_int_fmt) else $error("bad int word");
	property p_rst_end;
		bus_reset && busy |-> ##[1:4] !busy;
	endproperty
	a_rst_end: assert property (p_rst_end) else $error("reset kept run");
	property p_tmo_end;
		req_ack_timeout && busy |-> ##[1:4] !busy;
	endproperty
	a_tmo_end: assert property (p_tmo_end) else $error("timeout kept run");
	property p_busy_cause;
		$rose(busy) |-> cmd_seen != 3'h0;
	endproperty
	a_busy_cause: assert property (p_busy_cause) else $error("run no cmd");
	property p_ack_free;
		ack_held && bus_free |-> ##[1:4] !ack_held;
	endproperty
	a_ack_free: assert property (p_ack_free) else $error("ack kept");
	c_done: cover property ($fell(busy));
	c_reset: cover property (bus_reset && busy);
	c_ack: cover property (ack_held && bus_free);
endmodule
`default_nettype wire

/* tb/scsi_peer.sv */
// behavioural remote target on the scsi side
`timescale 1ns/1ns
`default_nettype none
module scsi_peer (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic busy,
	input wire logic [3:0] mode,
	output logic bus_free,
	output logic bus_reset,
	output logic arb_won,
	output logic arb_lost,
	output logic reselected,
	output logic sel_busy,
	output logic cmd_pause,
	output logic req,
	output logic [2:0] req_phase,
	output logic byte_done,
	output logic req_ack_timeout,
	output logic single_msg_in,
	output logic single_status_in
);
	logic [7:0] cnt;
	// cycles since the run began, saturating
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt <= 8'h00;
		end else begin
			cnt <= busy ? cnt + {7'h0, cnt != 8'hff} : 8'h00;
		end
	end
	// mode 1 wrong phase, 2 no answer, 3 stall, 4 bus never free,
	// 5 pause, 6 lost then reselected, 7 message in, 8 free in command,
	// 9 phase change, 10 free before the first request
	// bus free while idle and before arbitration except in mode 4, later only in modes 2, 8 and 10, so selection is not cut short
	assign bus_free = mode != 4'h4 && (!busy || cnt < 8'h02 || mode == 4'h2
		|| (mode == 4'h8 && cnt == 8'h12) || (mode == 4'ha && cnt == 8'h05));
	assign bus_reset = mode == 4'h4 && busy && cnt == 8'h02;
	assign arb_won = busy;
	assign arb_lost = mode == 4'h6 && busy;
	assign reselected = mode == 4'h6 && busy && cnt >= 8'h02;
	assign cmd_pause = mode == 4'h5 && busy;
	assign sel_busy = busy && mode != 4'h2;
	assign req = busy && mode != 4'h2 && cnt >= 8'h10 && cnt[1:0] == 2'h0;
	assign byte_done = busy && mode == 4'h0 && cnt > 8'h10
		&& cnt[1:0] == 2'h1;
	assign req_phase = (mode == 4'h1 || mode == 4'h7) ? 3'h7
		: (mode == 4'h9 && cnt >= 8'h14) ? 3'h3 : 3'h2;
	assign req_ack_timeout = mode == 4'h3 && busy && cnt == 8'h16;
	assign single_msg_in = mode == 4'h7;
	assign single_status_in = mode == 4'h1;
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// testbench for the phase sequencer
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [3:0] mode = 4'h0;
	logic [31:0] hrdata;
	logic hreadyout, hresp, bus_free, bus_reset, arb_won, sel_busy, req;
	logic byte_done, req_ack_timeout, phase_drive, atn, ack_held, busy;
	logic arb_lost, reselected, cmd_pause, single_msg_in, single_status_in;
	logic [2:0] req_phase, drive_phase;
	int error_cnt = 0;
	int checked = 0;
	int cyc = 0;
	phase_sequencer dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .bus_free(bus_free),
		.bus_reset(bus_reset), .arb_won(arb_won), .arb_lost(arb_lost),
		.reselected(reselected), .sel_busy(sel_busy),
		.cmd_pause(cmd_pause), .req(req),
		.req_phase(req_phase), .byte_done(byte_done),
		.req_ack_timeout(req_ack_timeout), .single_msg_in(single_msg_in),
		.single_status_in(single_status_in), .drive_phase(drive_phase),
		.phase_drive(phase_drive), .atn(atn), .ack_held(ack_held), .busy(busy));
	scsi_peer peer_u (.hclk(hclk), .hresetn(hresetn), .busy(busy), .mode(mode),
		.bus_free(bus_free), .bus_reset(bus_reset), .arb_won(arb_won),
		.arb_lost(arb_lost), .reselected(reselected), .cmd_pause(cmd_pause),
		.sel_busy(sel_busy), .req(req), .req_phase(req_phase),
		.byte_done(byte_done), .req_ack_timeout(req_ack_timeout),
		.single_msg_in(single_msg_in), .single_status_in(single_status_in));
	// clock and cycle count
	always #2 hclk = ~hclk;
	always @(posedge hclk) cyc <= cyc + 1;
	task test_done;
		$display("checked %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task chk(input string n, input logic [16:0] e, input logic [16:0] g);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	// one single ahb transfer, waits for hready in both phases
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
		hwdata <= ~d;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask
	// poll the interrupt word until an entry is valid
	task get_int(input string n, input logic [15:0] e);
		logic [31:0] r;
		r = 32'h0;
		for (int i = 0; i < 1500 && r[16] !== 1'b1; i++) bus(1'b0, 8'h18, 32'h0, r);
		chk(n, {1'b1, e}, r[16:0]);
	endtask
	// command word with odd parity, or even when bad is set
	function automatic logic [31:0] cw(input logic [4:0] op, input logic bad);
		return {23'h0, ~^op ^ bad, 3'h0, op};
	endfunction
	task rst;
		hresetn <= 1'b0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
	endtask
	// fresh reset, setup, then the command
	task run(input logic [7:0] ctrl, input logic [7:0] cfg, input logic [3:0] m,
		input logic [7:0] len, input logic [31:0] cmd);
		rst();
		mode <= m;
		wr(8'h04, {24'h0, ctrl});
		wr(8'h0c, {24'h0, cfg});
		wr(8'h08, {24'h0, len});
		wr(8'h10, 32'h1);
		wr(8'h00, cmd);
	endtask
	task t_refuse;
		logic [31:0] r;
		run(8'h00, 8'h2a, 4'h0, 8'h06, cw(5'h00, 1'b0));
		get_int("no nexus", 16'h6500);
		run(8'h04, 8'h2a, 4'h0, 8'h06, cw(5'h00, 1'b0));
		get_int("target op", 16'h6500);
		run(8'h04, 8'h2a, 4'h0, 8'h06, cw(5'h1f, 1'b0));
		get_int("undefined op", 16'h6500);
		run(8'h04, 8'h2a, 4'h0, 8'h06, cw(5'h04, 1'b1));
		wr(8'h00, cw(5'h04, 1'b0));
		get_int("parity", 16'h6600);
		get_int("pending first", 16'h6400);
		bus(1'b0, 8'h40, 32'h0, r);
		chk("unmapped", 17'h0, r[16:0]);
	endtask
	task t_sel_done;
		run(8'h04, 8'h2a, 4'h0, 8'h06, cw(5'h04, 1'b0));
		get_int("done manual", 16'h6004);
		get_int("free ack held", 16'h3100);
		run(8'h05, 8'h2a, 4'h0, 8'h06, cw(5'h04, 1'b0));
		wr(8'h00, cw(5'h04, 1'b0));
		get_int("done auto", 16'h600c);
		get_int("double", 16'h6400);
		run(8'h04, 8'h2a, 4'h0, 8'h21, cw(5'h05, 1'b0));
		get_int("long msg", 16'h6403);
	endtask
	task t_sel_fault;
		run(8'h04, 8'h2a, 4'h1, 8'h06, cw(5'h04, 1'b0));
		get_int("wrong phase", 16'h5403);
		run(8'h04, 8'h6a, 4'h0, 8'h06, cw(5'h04, 1'b0));
		get_int("group 3/4", 16'h6503);
		run(8'h04, 8'h2a, 4'h3, 8'h06, cw(5'h04, 1'b0));
		get_int("handshake timeout", 16'h2c03);
		run(8'h04, 8'h2a, 4'h4, 8'h06, cw(5'h04, 1'b0));
		get_int("bus reset", 16'h0100);
		run(8'h04, 8'h2a, 4'h8, 8'h06, cw(5'h04, 1'b0));
		get_int("free in cmd", 16'h3103);
		run(8'h04, 8'h2a, 4'h9, 8'h06, cw(5'h04, 1'b0));
		get_int("phase change", 16'h3203);
		run(8'h04, 8'h2a, 4'ha, 8'h06, cw(5'h04, 1'b0));
		get_int("free after nexus", 16'h7002);
		run(8'h04, 8'h2a, 4'h5, 8'h06, cw(5'h04, 1'b0));
		get_int("pause", 16'h6701);
		run(8'h04, 8'h2a, 4'h6, 8'h06, cw(5'h04, 1'b0));
		get_int("reselected", 16'h6400);
	endtask
	// message-out expected but missed: attention kept or negated
	task t_atn;
		run(8'h04, 8'h2a, 4'h1, 8'h06, cw(5'h06, 1'b0));
		get_int("msg out missed", 16'h5403);
		chk("atn kept", 17'h1, {16'h0, atn});
		run(8'h06, 8'h2a, 4'h7, 8'h06, cw(5'h06, 1'b0));
		get_int("auto msg", 16'h5503);
		chk("atn off msg", 17'h0, {16'h0, atn});
		run(8'h06, 8'h2a, 4'h1, 8'h06, cw(5'h06, 1'b0));
		get_int("auto status", 16'h5603);
		chk("atn off status", 17'h0, {16'h0, atn});
	endtask
	// nexus first, role refusals, then one target op with phase and step
	task t_target(input logic [4:0] op, input logic [2:0] ph, input string n);
		logic [31:0] r;
		run(8'h05, 8'h2a, 4'h0, 8'h06, cw(5'h04, 1'b0));
		get_int("nexus done", 16'h600c);
		wr(8'h00, cw(op, 1'b0));
		get_int("role", 16'h6500);
		wr(8'h00, cw(5'h04, 1'b0));
		get_int("sel with nexus", 16'h6500);
		wr(8'h04, 32'h0);
		wr(8'h00, cw(op, 1'b0));
		bus(1'b0, 8'h1c, 32'h0, r);
		chk("step one", 17'h1, {9'h0, r[15:8]});
		chk(n, {13'h0, 1'b1, ph}, {13'h0, phase_drive, drive_phase});
		get_int("target done", 16'h6002);
	endtask
	task t_sel_tmo;
		int t;
		t = cyc;
		run(8'h04, 8'h2a, 4'h2, 8'h06, cw(5'h04, 1'b0));
		get_int("sel timeout", 16'h8202);
		chk("retry span", 17'h1, 17'(cyc - t >= 512));
	endtask
	initial begin
		rst();
		t_refuse();
		t_sel_done();
		t_sel_fault();
		t_atn();
		t_target(5'h00, 3'h1, "data in");
		t_target(5'h01, 3'h0, "data out");
		t_target(5'h02, 3'h3, "status");
		t_target(5'h03, 3'h2, "command");
		t_sel_tmo();
		test_done();
	end
	// watchdog against a hang
	initial begin
		#100000;
		error_cnt++;
		$display("BAD watchdog expected end seen hang");
		test_done();
	end
endmodule
bind phase_sequencer seq_chk chk_u (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.bus_free(bus_free), .bus_reset(bus_reset),
	.req_ack_timeout(req_ack_timeout), .ack_held(ack_held), .busy(busy));
`default_nettype wire
